//--- inc/dic_defines.svh
`ifndef DIC_DEFINES_SVH
`define DIC_DEFINES_SVH
// What this block does
// R1 - sample data enters the digital path only while transmit_gate is high
// R2 - gate low forces the digital section to zero and ignores both buses
// R3 - gate-marked interleave: first sample after gate rise is A, then alternate
// R4 - with B-marker enabled, a sample with the B flag high is channel B
// R5 - source raises the B flag with every channel B sample
// R6 - serial data pin is two-way in 3-wire mode, input only in 4-wire mode
// R7 - serial port comes up in 3-wire mode after chip reset
// R8 - serial_read_out is high impedance while 3-wire mode is selected
// R9 - 4-wire reads return on serial_read_out; serial data pin stays input
// R10 - host frames transfers with serial_select_n low; always an input
// R11 - chip_reset_n low resets all logic; pulled high when undriven (here rst_n leaves the pin synchronisers and power-down flops unreset)
// R12 - sleep high enters power-down asynchronously; pulled low when undriven
// R13 - phase_sync_strobe can initialise oscillator, mixer, divider, fifo
// R14 - pll mode: lock pin shows lock (high only when locked) or clock
// R15 - external clock mode: lock pin shows a clock at the input rate
// R16 - reference_select_pin drives only while analog_test_field is nonzero
// R17 - true output full scale at all ones, complement at all zeros
// R18 - factory_test_pin held at digital ground in normal use
// R19 - bit 15 is the msb by default; a register bit reverses the order
// R20 - input_rate_clock paces input in pll/dual modes; unused with fifo off
// R21 - gate-marked alternation restarts at channel A on each gate rise

// =======================================
// register offsets
`define DIC_CTRL_OFS 8'h00
`define DIC_SYNC_OFS 8'h01
`define DIC_STAT_OFS 8'h02
`define DIC_SPI_OFS 8'h08
`define DIC_ANALOG_TEST_FIELD_OFS 8'h1b
// =======================================
// field positions
`define DIC_CTRL_IL 0
`define DIC_CTRL_BMARK 1
`define DIC_CTRL_BREV 2
`define DIC_CTRL_FIFO 3
`define DIC_CTRL_CKM_LO 4
`define DIC_CTRL_CKM_HI 5
`define DIC_CTRL_LKCLK 6
`define DIC_SPI_4W 1
`define DIC_ANALOG_TEST_FIELD_LO 3
`define DIC_ANALOG_TEST_FIELD_HI 7
// =======================================
// reset values and timing
`define DIC_CTRL_RST 8'h00
`define DIC_SYNC_RST 4'h0
`define DIC_SPI_RST 8'h00
`define DIC_ANALOG_TEST_FIELD_RST 5'h00
`define DIC_RATE_DIV 8'h04
`endif

//--- inc/dic_pkg.sv
package dic_pkg;
    typedef enum logic [1:0] {
        DIC_CK_PLL = 2'b00,
        DIC_CK_DUAL = 2'b01,
        DIC_CK_EXT = 2'b10,
        DIC_CK_RSV = 2'b11
    } dic_ckmode_t;
    typedef enum logic {
        DIC_CH_A = 1'b0,
        DIC_CH_B = 1'b1
    } dic_chan_t;
    typedef struct packed {
        logic [15:0] a;
        logic [15:0] b;
    } dic_pair_t;
    typedef struct packed {
        logic nco;
        logic mixer;
        logic clkdiv;
        logic fifo;
    } dic_sync_t;
endpackage

//--- design/dic_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dic_defines.svh"
module dic_top (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // sample pins
    input wire logic transmit_gate,
    input wire logic b_sample_flag,
    input wire logic input_rate_clock,
    input wire dic_pkg::dic_pair_t sample_in,
    // dac codes
    output dic_pkg::dic_pair_t dac_true,
    output dic_pkg::dic_pair_t dac_comp,
    output logic valid_a,
    output logic valid_b,
    // serial pins
    input wire logic serial_select_n,
    input wire logic ser_rd_bit,
    input wire logic ser_rd_en,
    output logic sdio_o,
    output logic sdio_oe,
    output logic serial_read_out,
    output logic serial_read_out_oe,
    // control pins
    input wire logic sleep,
    input wire logic phase_sync_strobe,
    input wire logic pll_locked,
    input wire logic reference_select_in,
    input wire logic factory_test_pin,
    output logic power_down,
    output dic_pkg::dic_sync_t sync_init,
    output logic loop_lock_out,
    output logic reference_select_o,
    output logic reference_select_oe
);
    // =======================================
    // pin synchronisers
    logic [6:0] s1_r, s2_r;
    logic [15:0] da1_r, da2_r, db1_r, db2_r;
    logic gate_s, flag_s, c1_s, sel_n_s, strb_s, lock_s, ref_s, ftest_s;
    assign {gate_s, flag_s, c1_s, sel_n_s, strb_s, lock_s, ref_s} = s2_r;
    logic ft1_r, ft2_r;
    assign ftest_s = ft2_r;
    always_ff @(posedge mclk) begin
        s1_r <= {transmit_gate, b_sample_flag, input_rate_clock,
                 serial_select_n, phase_sync_strobe, pll_locked, reference_select_in};
        s2_r <= s1_r;
        da1_r <= sample_in.a;
        da2_r <= da1_r;
        db1_r <= sample_in.b;
        db2_r <= db1_r;
        ft1_r <= factory_test_pin;
        ft2_r <= ft1_r;
    end

    // =======================================
    // registers
    logic [7:0] ctrl_r, ctrl_nxt, spi_r, spi_nxt, rdata_nxt;
    logic [3:0] sync_r, sync_nxt;
    logic [4:0] analog_test_field_r, analog_test_field_nxt;
    logic il, bmark, brev, fifo_en, lk_clk, four_wire;
    dic_pkg::dic_ckmode_t ckm;
    assign il = ctrl_r[`DIC_CTRL_IL];
    assign bmark = ctrl_r[`DIC_CTRL_BMARK];
    assign brev = ctrl_r[`DIC_CTRL_BREV];
    assign fifo_en = ctrl_r[`DIC_CTRL_FIFO];
    assign lk_clk = ctrl_r[`DIC_CTRL_LKCLK];
    assign ckm = dic_pkg::dic_ckmode_t'(ctrl_r[`DIC_CTRL_CKM_HI:`DIC_CTRL_CKM_LO]);
    assign four_wire = spi_r[`DIC_SPI_4W];
    dic_pkg::dic_chan_t ch_r, ch_nxt;

    always_comb begin
        ctrl_nxt = ctrl_r;
        sync_nxt = sync_r;
        spi_nxt = spi_r;
        analog_test_field_nxt = analog_test_field_r;
        rdata_nxt = 8'h00;
        if (reg_wr) begin
            if (reg_addr == `DIC_CTRL_OFS) begin
                ctrl_nxt = reg_wdata;
            end else if (reg_addr == `DIC_SYNC_OFS) begin
                sync_nxt = reg_wdata[3:0];
            end else if (reg_addr == `DIC_SPI_OFS) begin
                spi_nxt = reg_wdata;
            end else if (reg_addr == `DIC_ANALOG_TEST_FIELD_OFS) begin
                analog_test_field_nxt = reg_wdata[`DIC_ANALOG_TEST_FIELD_HI:`DIC_ANALOG_TEST_FIELD_LO];
            end
        end
        if (reg_rd) begin
            if (reg_addr == `DIC_CTRL_OFS) begin
                rdata_nxt = ctrl_r;
            end else if (reg_addr == `DIC_SYNC_OFS) begin
                rdata_nxt = {4'h0, sync_r};
            end else if (reg_addr == `DIC_STAT_OFS) begin
                rdata_nxt = {2'h0, ch_r == dic_pkg::DIC_CH_B, ftest_s, ref_s,
                             power_down, gate_s, lock_s};
            end else if (reg_addr == `DIC_SPI_OFS) begin
                rdata_nxt = spi_r;
            end else if (reg_addr == `DIC_ANALOG_TEST_FIELD_OFS) begin
                rdata_nxt = {analog_test_field_r, 3'h0};
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin // R11
            ctrl_r <= `DIC_CTRL_RST;
            sync_r <= `DIC_SYNC_RST;
            spi_r <= `DIC_SPI_RST; // R7
            analog_test_field_r <= `DIC_ANALOG_TEST_FIELD_RST;
            reg_rdata <= 8'h00;
        end else begin
            ctrl_r <= ctrl_nxt;
            sync_r <= sync_nxt;
            spi_r <= spi_nxt;
            analog_test_field_r <= analog_test_field_nxt;
            reg_rdata <= rdata_nxt;
        end
    end

    // =======================================
    // power-down: sleep sets at once; release runs through two flops to avoid metastability
    logic pd1_r;
    always_ff @(posedge mclk or posedge sleep) begin
        if (sleep) begin
            pd1_r <= 1'b1;
            power_down <= 1'b1; // R12
        end else begin
            pd1_r <= 1'b0;
            power_down <= pd1_r;
        end
    end

    // =======================================
    // sample path
    function automatic logic [15:0] dic_order(input logic [15:0] d, input logic rev);
        logic [15:0] r;
        r = d;
        if (rev) begin
            for (int i = 0; i < 16; i++) begin
                r[i] = d[15 - i];
            end
        end
        return r;
    endfunction

    logic gate_d_r, c1_d_r, gate_rise, strobe, take;
    logic [15:0] a_ord, b_ord;
    dic_pkg::dic_pair_t code_nxt;
    logic va_nxt, vb_nxt;
    assign gate_rise = gate_s & ~gate_d_r;
    // input_rate_clock paces input only while the fifo uses it
    assign strobe = fifo_en ? (c1_s & ~c1_d_r) : 1'b1; // R20
    assign take = gate_s & strobe & ~power_down; // R1
    assign a_ord = dic_order(da2_r, brev); // R19
    assign b_ord = dic_order(db2_r, brev); // R19

    always_comb begin
        code_nxt = '0; // R2
        va_nxt = 1'b0;
        vb_nxt = 1'b0;
        ch_nxt = gate_s ? ch_r : dic_pkg::DIC_CH_A; // R21
        if (gate_rise) begin
            ch_nxt = dic_pkg::DIC_CH_A; // R21
        end
        if (take) begin
            code_nxt = {dac_true.a, dac_true.b};
            if (!il) begin
                code_nxt = {a_ord, b_ord};
                va_nxt = 1'b1;
                vb_nxt = 1'b1;
            end else if (bmark) begin
                // source must flag every b sample, not just the first
                if (flag_s) begin // R4 R5
                    code_nxt.b = a_ord;
                    vb_nxt = 1'b1;
                end else begin
                    code_nxt.a = a_ord;
                    va_nxt = 1'b1;
                end
            end else begin
                if (gate_rise || ch_r == dic_pkg::DIC_CH_A) begin // R3
                    code_nxt.a = a_ord;
                    va_nxt = 1'b1;
                    ch_nxt = dic_pkg::DIC_CH_B;
                end else begin
                    code_nxt.b = a_ord;
                    vb_nxt = 1'b1;
                    ch_nxt = dic_pkg::DIC_CH_A;
                end
            end
        end else if (!gate_s || power_down) begin
            code_nxt = '0; // R2
        end else begin
            code_nxt = dac_true;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            gate_d_r <= 1'b0;
            c1_d_r <= 1'b0;
            ch_r <= dic_pkg::DIC_CH_A;
            dac_true <= '0;
            dac_comp <= '1;
            valid_a <= 1'b0;
            valid_b <= 1'b0;
        end else begin
            gate_d_r <= gate_s;
            c1_d_r <= c1_s;
            ch_r <= ch_nxt;
            dac_true <= code_nxt;
            dac_comp <= ~code_nxt; // R17
            valid_a <= va_nxt;
            valid_b <= vb_nxt;
        end
    end

    // =======================================
    // serial pins; select is only ever sampled
    logic rd_act;
    assign rd_act = ~sel_n_s & ser_rd_en; // R10
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sdio_o <= 1'b0;
            sdio_oe <= 1'b0;
            serial_read_out <= 1'b0;
            serial_read_out_oe <= 1'b0;
        end else begin
            sdio_o <= ser_rd_bit;
            sdio_oe <= rd_act & ~four_wire; // R6
            serial_read_out <= ser_rd_bit; // R9
            serial_read_out_oe <= rd_act & four_wire; // R8 R9
        end
    end

    // =======================================
    // phase sync, lock pin, reference select
    logic strb_d_r;
    logic [7:0] div_r, div_nxt;
    logic rclk_r, rclk_nxt, lock_nxt;
    always_comb begin
        div_nxt = div_r + 8'h01;
        rclk_nxt = rclk_r;
        if (div_r == `DIC_RATE_DIV - 8'h01) begin
            div_nxt = 8'h00;
            rclk_nxt = ~rclk_r;
        end
        if (ckm == dic_pkg::DIC_CK_EXT) begin
            lock_nxt = rclk_r; // R15
        end else if (lk_clk) begin
            lock_nxt = rclk_r; // R14
        end else begin
            lock_nxt = lock_s; // R14
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            strb_d_r <= 1'b0;
            sync_init <= '0;
            div_r <= 8'h00;
            rclk_r <= 1'b0;
            loop_lock_out <= 1'b0;
            reference_select_o <= 1'b0;
            reference_select_oe <= 1'b0;
        end else begin
            strb_d_r <= strb_s;
            sync_init <= (strb_s & ~strb_d_r) ? sync_r : 4'h0; // R13
            div_r <= div_nxt;
            rclk_r <= rclk_nxt;
            loop_lock_out <= lock_nxt;
            reference_select_o <= 1'b1;
            reference_select_oe <= analog_test_field_r != 5'h00; // R16
        end
    end

    // =======================================
    // assertions
    default clocking dic_cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_gate_low_zero: assert property (!gate_s |=> dac_true == '0) // R2
        else $error("codes not zero with gate low");
    a_valid_needs_gate: assert property ((valid_a || valid_b) |-> $past(gate_s)) // R1
        else $error("sample taken with gate low");
    a_first_is_a: assert property (take && gate_rise && il && !bmark |=> valid_a && !valid_b) // R3
        else $error("first sample after gate rise not channel a");
    a_alternate_b: assert property (take && il && !bmark && !gate_rise && valid_a
        |=> valid_b) // R3
        else $error("alternation broken");
    a_flag_b: assert property (take && il && bmark && flag_s |=> valid_b && !valid_a) // R4
        else $error("flagged sample not channel b");
    a_sdo_hiz: assert property (!four_wire |=> !serial_read_out_oe) // R8
        else $error("serial output driven in 3-wire mode");
    a_sdio_input: assert property (four_wire |=> !sdio_oe) // R6
        else $error("serial data pin driven in 4-wire mode");
    a_reset_3wire: assert property ($rose(rst_n) |-> !four_wire) // R7
        else $error("not 3-wire after reset");
    a_comp_code: assert property (dac_comp == ~dac_true) // R17
        else $error("complement output mismatch");
    a_ref_oe: assert property (reference_select_oe == ($past(analog_test_field_r) != 5'h00)) // R16
        else $error("reference select drive mismatch");
    a_lock_show: assert property (ckm == dic_pkg::DIC_CK_PLL && !lk_clk ##1
        ckm == dic_pkg::DIC_CK_PLL |-> loop_lock_out == $past(lock_s)) // R14
        else $error("lock pin does not follow lock");
    a_sync_pulse: assert property (strb_s && !strb_d_r |=> sync_init == $past(sync_r)) // R13
        else $error("sync strobe not forwarded");

    c_interleave: cover property (take && il && !bmark ##1 take ##1 valid_b);
    c_flagged: cover property (take && il && bmark && flag_s);
    c_four_wire_read: cover property (serial_read_out_oe);
    c_ext_clock: cover property (ckm == dic_pkg::DIC_CK_EXT && $rose(loop_lock_out));
endmodule
`default_nettype wire

//--- verif/dic_src.sv
`timescale 1ns/1ps
`default_nettype none
// =======================================
// baseband source model
module dic_src (
    // clock
    input wire logic mclk,
    // control
    input wire logic en,
    // sample pins
    output logic transmit_gate,
    output logic b_sample_flag,
    output dic_pkg::dic_pair_t sample_in
);
    int cnt = 0;
    initial begin
        transmit_gate = 1'b0;
        b_sample_flag = 1'b0;
        sample_in = '0;
    end
    // bus and flag change every cycle, gated or not, so a leak past the gate shows up
    always @(posedge mclk) begin
        sample_in <= dic_pkg::dic_pair_t'($urandom);
        b_sample_flag <= 1'($urandom);
        if (!en) begin
            transmit_gate <= 1'b0;
            cnt <= 0;
        end else if (cnt == 0) begin
            transmit_gate <= ~transmit_gate;
            cnt <= 1 + $urandom % 8;
        end else begin
            cnt <= cnt - 1;
        end
    end
endmodule
`default_nettype wire

//--- verif/tb_dac_input_and_control_pins.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dac_input_and_control_pins;
    // =======================================
    // signals
    logic mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd;
    logic transmit_gate, b_sample_flag, input_rate_clock = 1'b0;
    dic_pkg::dic_pair_t sample_in, dac_true, dac_comp, exp_code;
    logic valid_a, valid_b, sdio_o, sdio_oe, serial_read_out, serial_read_out_oe;
    logic serial_select_n = 1'b1, ser_rd_bit = 1'b0, ser_rd_en = 1'b0, sleep = 1'b0;
    logic phase_sync_strobe = 1'b0, pll_locked = 1'b0, power_down, loop_lock_out;
    logic reference_select_o, reference_select_oe, lk;
    dic_pkg::dic_sync_t sync_init;
    logic src_en = 1'b0, mon = 1'b0, il = 1'b0, bm = 1'b0, rev = 1'b0, nb = 1'b0;
    logic fifo = 1'b0, ref_in = 1'b1;
    logic isb, exp_a, exp_b;
    logic g [0:3];
    logic f [0:3];
    logic c [0:4];
    dic_pkg::dic_pair_t s [0:3];
    logic [3:0] cfg [5] = '{4'b0000, 4'b0100, 4'b0001, 4'b0111, 4'b1001};
    logic [7:0] refv [4] = '{8'h08, 8'h07, 8'hf8, 8'h00};
    logic [7:0] lkv [2] = '{8'h40, 8'h20};
    logic [3:0] seen_sync;
    int err_count = 0, checked = 0, cyc = 0, n, t;

    always #12.5 mclk = ~mclk;
    always @(posedge mclk) input_rate_clock <= ~input_rate_clock;

    dic_top i_dic_top (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .transmit_gate(transmit_gate),
        .b_sample_flag(b_sample_flag), .input_rate_clock(input_rate_clock),
        .sample_in(sample_in), .dac_true(dac_true), .dac_comp(dac_comp), .valid_a(valid_a),
        .valid_b(valid_b), .serial_select_n(serial_select_n), .ser_rd_bit(ser_rd_bit),
        .ser_rd_en(ser_rd_en), .sdio_o(sdio_o), .sdio_oe(sdio_oe),
        .serial_read_out(serial_read_out), .serial_read_out_oe(serial_read_out_oe),
        .sleep(sleep), .phase_sync_strobe(phase_sync_strobe), .pll_locked(pll_locked),
        .reference_select_in(ref_in), .factory_test_pin(1'b0), .power_down(power_down),
        .sync_init(sync_init), .loop_lock_out(loop_lock_out),
        .reference_select_o(reference_select_o), .reference_select_oe(reference_select_oe));
    dic_src i_dic_src (.mclk(mclk), .en(src_en), .transmit_gate(transmit_gate),
        .b_sample_flag(b_sample_flag), .sample_in(sample_in));

    // =======================================
    // checking and bus tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
        checked++;
        if (seen !== expv) begin
            err_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    function automatic logic [15:0] ord(input logic [15:0] x);
        logic [15:0] y;
        for (int i = 0; i < 16; i++) y[i] = rev ? x[15 - i] : x[i];
        return y;
    endfunction

    // =======================================
    // sample path model: pins reach the codes three edges later
    always @(negedge mclk) begin
        c[4] = c[3];
        for (int i = 3; i > 0; i--) begin
            c[i] = c[i - 1];
            g[i] = g[i - 1];
            f[i] = f[i - 1];
            s[i] = s[i - 1];
        end
        g[0] = transmit_gate;
        f[0] = b_sample_flag;
        s[0] = sample_in;
        c[0] = input_rate_clock;
        exp_a = 1'b0;
        exp_b = 1'b0;
        if (g[3] !== 1'b1) begin
            exp_code = '0;
            nb = 1'b0;
        end else if (fifo && !(c[3] && !c[4])) begin
            // no rise of the input rate clock: codes hold, no valid
        end else if (!il) begin
            exp_code = {ord(s[3].a), ord(s[3].b)};
            exp_a = 1'b1;
            exp_b = 1'b1;
        end else begin
            isb = bm ? f[3] : nb;
            nb = !isb;
            if (isb) exp_code.b = ord(s[3].a);
            else exp_code.a = ord(s[3].a);
            exp_a = !isb;
            exp_b = isb;
        end
        if (mon) begin
            chk(dac_true, exp_code);
            chk(dac_comp, ~exp_code);
            chk({valid_a, valid_b}, {exp_a, exp_b});
        end
    end

    // timeout well beyond the roughly 1750 cycles the sequence needs
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            err_count++;
            wrap_up();
        end
    end

    // =======================================
    // main sequence
    initial begin
        void'($urandom(32'h7572));
        repeat (5) @(posedge mclk);
        #1;
        chk(dac_true, 32'h0);
        chk(dac_comp, 32'hffffffff);
        @(posedge mclk) rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        mon = 1'b1;
        rd_reg(8'h08, rd);
        chk(rd, 8'h00);
        rd_reg(8'h55, rd);
        chk(rd, 8'h00);
        for (int m = 0; m < 5; m++) begin
            wr_reg(8'h00, {4'h0, cfg[m]});
            {fifo, rev, bm, il} = cfg[m];
            src_en <= 1'b1;
            repeat (300) @(posedge mclk);
            src_en <= 1'b0;
            repeat (8) @(posedge mclk);
        end
        // sleep is sampled after the edge here, so only an async set can show at once
        @(posedge mclk) sleep <= 1'b1;
        #1;
        chk(power_down, 1'b1);
        rd_reg(8'h02, rd);
        chk(rd[4:2], 3'b011);
        @(posedge mclk) sleep <= 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        chk(power_down, 1'b0);
        @(posedge mclk) begin
            serial_select_n <= 1'b0;
            ser_rd_en <= 1'b1;
            ser_rd_bit <= 1'b1;
        end
        repeat (5) @(posedge mclk);
        #1;
        chk({sdio_o, sdio_oe, serial_read_out_oe}, 3'b110);
        wr_reg(8'h08, 8'h02);
        repeat (3) @(posedge mclk);
        #1;
        chk({sdio_oe, serial_read_out_oe, serial_read_out}, 3'b011);
        @(posedge mclk) serial_select_n <= 1'b1;
        repeat (5) @(posedge mclk);
        #1;
        chk({sdio_oe, serial_read_out_oe}, 2'b00);
        for (int i = 0; i < 4; i++) begin
            wr_reg(8'h01, 8'h01 << i);
            n = 0;
            seen_sync = 4'h0;
            phase_sync_strobe <= 1'b1;
            for (int k = 0; k < 10; k++) begin
                @(posedge mclk);
                if (k == 3) phase_sync_strobe <= 1'b0;
                #1;
                if (sync_init !== 4'h0) begin
                    n++;
                    seen_sync = sync_init;
                end
            end
            chk(n, 1);
            chk(seen_sync, 4'h1 << i);
        end
        foreach (refv[i]) begin
            wr_reg(8'h1b, refv[i]);
            repeat (3) @(posedge mclk);
            #1;
            chk({reference_select_oe, reference_select_o}, {refv[i][7:3] != 5'h00, 1'b1});
        end
        wr_reg(8'h00, 8'h00);
        @(posedge mclk) pll_locked <= 1'b1;
        repeat (6) @(posedge mclk);
        #1;
        chk(loop_lock_out, 1'b1);
        @(posedge mclk) pll_locked <= 1'b0;
        repeat (6) @(posedge mclk);
        #1;
        chk(loop_lock_out, 1'b0);
        // a divided clock of eight cycles toggles about eight times in 32 cycles
        foreach (lkv[j]) begin
            wr_reg(8'h00, lkv[j]);
            t = 0;
            lk = loop_lock_out;
            repeat (32) begin
                @(posedge mclk);
                #1;
                if (loop_lock_out !== lk) t++;
                lk = loop_lock_out;
            end
            chk(t >= 6 && t <= 10, 1'b1);
        end
        // a mid-run reset must bring back 3-wire mode and clear the control word
        @(posedge mclk) rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        rd_reg(8'h08, rd);
        chk(rd, 8'h00);
        rd_reg(8'h00, rd);
        chk(rd, 8'h00);
        wrap_up();
    end
endmodule
`default_nettype wire
